/* design/cc_timer_pkg.sv */
// Package: register map, field layout, reset values and types of the timer
package cc_timer_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_OPTION = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam logic [7:0] OFF_PRESC  = 8'h0c;
  localparam logic [7:0] OFF_CCR0   = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_MASK   = 8'h24;

  // Field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int OPT_OVF_BIT    = 0;
  localparam int OPT_CCS_LSB    = 4;
  localparam int STS_OVF_BIT    = 4;

  // Reset values and counter limits
  localparam logic [15:0] CNT_IDLE  = 16'hffff;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CCR_RST   = 16'h0000;
  localparam logic [7:0]  PRESC_RST = 8'h00;
  localparam logic [4:0]  MASK_RST  = 5'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Three-bit timer_mode_field encodings used here
  localparam logic [2:0] MODE_PWM  = 3'h4;
  localparam logic [2:0] MODE_FREE = 3'h5;

  typedef struct packed {
    logic [2:0] timer_mode_field;
    logic       count_enable_bit;
  } ctrl_t;

  typedef struct packed {
    logic       ovf;
    logic [3:0] chan;
  } events_t;

endpackage : cc_timer_pkg

/* design/capture_edge.sv */
// Two-stage synchroniser and rising-edge detector for the capture pins
`timescale 1ns/1ps
module capture_edge #(
  parameter int WIDTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] edge_pulse
);

  logic [WIDTH-1:0] sync1_r;
  logic [WIDTH-1:0] sync2_r;
  logic [WIDTH-1:0] last_r;
  logic [WIDTH-1:0] edge_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      last_r  <= '0;
      edge_r  <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      last_r  <= sync2_r;
      edge_r  <= sync2_r & ~last_r;
    end
  end

  assign edge_pulse = edge_r;

endmodule // capture_edge

/* design/cc_timer.sv */
// Free-running 16-bit capture/compare timer with AXI4-Lite registers
`timescale 1ns/1ps
module cc_timer #(
  parameter bit CAPTURE_EN = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  capture_input_pin,
  output logic [3:0]       timer_output_pin,
  output logic [3:0]       channel_match_irq,
  output logic             counter_overflow_irq,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  cc_timer_pkg::ctrl_t     ctrl_r;
  cc_timer_pkg::events_t   evt;
  cc_timer_pkg::events_t   evt_r;
  logic [3:0]  ccs_r;
  logic        ovf_flag_r;
  logic [7:0]  presc_r;
  logic [7:0]  div_r;
  logic [15:0] cnt_r;
  logic        started_r;
  logic        run_prev_r;
  logic [15:0] ccr_r [4];
  logic [3:0]  match_prev_r;
  logic [3:0]  out_r;
  logic [4:0]  sts_r;
  logic [4:0]  mask_r;

  // Bus capture registers
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [2:0] ccr_hit(input logic [7:0] a);
    // Bit 2 flags a channel register, low bits give the index
    if (a[7:4] == cc_timer_pkg::OFF_CCR0[7:4] && a[1:0] == 2'h0)
      return {1'b1, a[3:2]};
    return 3'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus write side
  wire wr_go   = aw_have_r && w_have_r && !bvalid_r;
  wire [2:0] wr_ccr = ccr_hit(awaddr_r);
  wire wr_ctrl = wr_go && hit(awaddr_r, cc_timer_pkg::OFF_CTRL);
  wire wr_opt  = wr_go && hit(awaddr_r, cc_timer_pkg::OFF_OPTION);
  wire wr_prs  = wr_go && hit(awaddr_r, cc_timer_pkg::OFF_PRESC);
  wire wr_sts  = wr_go && hit(awaddr_r, cc_timer_pkg::OFF_STATUS);
  wire wr_msk  = wr_go && hit(awaddr_r, cc_timer_pkg::OFF_MASK);
  wire wr_cnt  = wr_go && hit(awaddr_r, cc_timer_pkg::OFF_COUNT);
  wire wr_chan = wr_go && wr_ccr[2];
  wire wr_ok   = wr_ctrl || wr_opt || wr_prs || wr_sts || wr_msk ||
                 wr_cnt || wr_chan;

  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready  = !w_have_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= cc_timer_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok ? cc_timer_pkg::RESP_OKAY
                          : cc_timer_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and count clock
  // mode decode
  wire mode_ok = ctrl_r.timer_mode_field == cc_timer_pkg::MODE_FREE ||
                 ctrl_r.timer_mode_field == cc_timer_pkg::MODE_PWM;
  wire running = ctrl_r.count_enable_bit && mode_ok;
  wire is_pwm  = ctrl_r.timer_mode_field == cc_timer_pkg::MODE_PWM;
  wire tick    = running && div_r == presc_r;
  wire start   = running && !run_prev_r;
  assign evt.ovf = tick && started_r && cnt_r == cc_timer_pkg::CNT_MAX;

  // capture only in the capable unit
  wire [3:0] cap_sel = ccs_r & {4{CAPTURE_EN}};
  wire [3:0] cap_edge;

  capture_edge #(.WIDTH(4)) u_edge (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin_in     (capture_input_pin),
    .edge_pulse (cap_edge)
  );

  logic [3:0] match_now;
  logic [3:0] match_rise;
  logic [3:0] cap_evt;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // compare against the live register, no buffer
      match_now[i]  = started_r && !cap_sel[i] && cnt_r == ccr_r[i];
      match_rise[i] = match_now[i] && !match_prev_r[i];
      // capture on a valid edge while counting
      cap_evt[i]    = running && cap_sel[i] && cap_edge[i];
      // PWM raises at the match, otherwise a step later
      evt.chan[i]   = cap_evt[i] ||
                      (is_pwm ? match_rise[i] : tick && match_now[i]);
    end
  end

  // Idle counter sits at FFFFH so the first tick lands on 0000H
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r      <= cc_timer_pkg::CNT_IDLE;
      div_r      <= 8'h00;
      started_r  <= 1'b0;
      run_prev_r <= 1'b0;
    end else begin
      run_prev_r <= running;
      if (!running) begin
        cnt_r     <= cc_timer_pkg::CNT_IDLE;
        div_r     <= 8'h00;
        started_r <= 1'b0;
      end else begin
        div_r <= tick ? 8'h00 : div_r + 8'h01;
        if (tick) begin
          // counter never cleared by a match
          cnt_r     <= cnt_r + 16'h0001;
          started_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels, pins, flags
  logic [15:0] ccr_nxt [4];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ccr_nxt[i] = ccr_r[i];
      if (cap_evt[i]) begin
        ccr_nxt[i] = cnt_r;
      end else if (wr_chan && wr_ccr[1:0] == 2'(i) && !cap_sel[i]) begin
        if (wstrb_r[0]) ccr_nxt[i][7:0]  = wdata_r[7:0];
        if (wstrb_r[1]) ccr_nxt[i][15:8] = wdata_r[15:8];
      end
    end
  end

  // option write with bit 0 low clears the flag
  wire ovf_clr = wr_opt && wstrb_r[0] && !wdata_r[cc_timer_pkg::OPT_OVF_BIT];
  wire ovf_flag_nxt = evt.ovf || (ovf_flag_r && !ovf_clr);

  wire [4:0] sts_w1c = (wr_sts && wstrb_r[0]) ? wdata_r[4:0] : 5'h00;
  wire [4:0] sts_nxt = (sts_r & ~sts_w1c) | evt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) ccr_r[i] <= cc_timer_pkg::CCR_RST;
      match_prev_r <= 4'h0;
      out_r        <= 4'h0;
      ovf_flag_r   <= 1'b0;
      sts_r        <= 5'h00;
      evt_r        <= '0;
    end else begin
      for (int i = 0; i < 4; i++) ccr_r[i] <= ccr_nxt[i];
      match_prev_r <= match_now;
      out_r        <= out_r ^ (~cap_sel & ({4{start}} | match_rise));
      ovf_flag_r   <= ovf_flag_nxt;
      sts_r        <= sts_nxt;
      evt_r        <= evt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r  <= '0;
      ccs_r   <= 4'h0;
      presc_r <= cc_timer_pkg::PRESC_RST;
      mask_r  <= cc_timer_pkg::MASK_RST;
    end else begin
      if (wr_ctrl && wstrb_r[0]) begin
        ctrl_r <= wdata_r[cc_timer_pkg::CTRL_MODE_LSB +: 4];
      end
      if (wr_opt && wstrb_r[0]) begin
        ccs_r <= wdata_r[cc_timer_pkg::OPT_CCS_LSB +: 4];
      end
      if (wr_prs && wstrb_r[0]) presc_r <= wdata_r[7:0];
      if (wr_msk && wstrb_r[0]) mask_r <= wdata_r[4:0];
    end
  end

  assign timer_output_pin     = out_r;
  assign channel_match_irq    = evt_r.chan;
  assign counter_overflow_irq = evt_r.ovf;
  assign irq                  = |(sts_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Bus read side
  wire [2:0] rd_ccr = ccr_hit(s_axi_araddr);
  wire rd_go = s_axi_arvalid && !rvalid_r;
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    if (hit(s_axi_araddr, cc_timer_pkg::OFF_CTRL)) begin
      rd_val[4:0] = {ctrl_r, 1'b0} >> 1;
    end else if (hit(s_axi_araddr, cc_timer_pkg::OFF_OPTION)) begin
      rd_val[7:0] = {ccs_r, 3'h0, ovf_flag_r};
    end else if (hit(s_axi_araddr, cc_timer_pkg::OFF_COUNT)) begin
      rd_val[15:0] = cnt_r;
    end else if (hit(s_axi_araddr, cc_timer_pkg::OFF_PRESC)) begin
      rd_val[7:0] = presc_r;
    end else if (hit(s_axi_araddr, cc_timer_pkg::OFF_STATUS)) begin
      rd_val[4:0] = sts_r;
    end else if (hit(s_axi_araddr, cc_timer_pkg::OFF_MASK)) begin
      rd_val[4:0] = mask_r;
    end else if (rd_ccr[2]) begin
      rd_val[15:0] = ccr_r[rd_ccr[1:0]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= cc_timer_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_ok ? cc_timer_pkg::RESP_OKAY : cc_timer_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_match_step(int i);
    match_now[i] && tick;
  endsequence

  a_pwm_irq_early: assert property (@(posedge aclk) disable iff (!aresetn)
    is_pwm && match_rise[0] |=> channel_match_irq[0])
    else $error("pwm match irq not at match");
  a_cmp_irq_late: assert property (@(posedge aclk) disable iff (!aresetn)
    (!is_pwm && !cap_sel[1]) and s_match_step(1) |=> channel_match_irq[1])
    else $error("compare irq missing after match step");
  a_idle_counter: assert property (@(posedge aclk) disable iff (!aresetn)
    !running |=> cnt_r == cc_timer_pkg::CNT_IDLE)
    else $error("counter moved while not running");
  a_capture_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    cap_sel[2] |-> !match_now[2])
    else $error("capture channel compared");
  a_start_invert: assert property (@(posedge aclk) disable iff (!aresetn)
    start && !cap_sel[0] && !match_rise[0] |=>
      timer_output_pin[0] != $past(timer_output_pin[0]))
    else $error("output not inverted at start");
  a_match_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    !start && match_rise[3] && !cap_sel[3] |=>
      timer_output_pin[3] != $past(timer_output_pin[3]) &&
      (cnt_r >= $past(cnt_r) || $past(cnt_r) == cc_timer_pkg::CNT_MAX))
    else $error("match did not invert pin");
  a_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    evt.ovf && running |=> cnt_r == 16'h0000 ##0 counter_overflow_irq)
    else $error("overflow did not wrap");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf_flag_r && !ovf_clr |=> ovf_flag_r)
    else $error("overflow flag dropped");
  a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf_clr && !evt.ovf |=> !ovf_flag_r)
    else $error("overflow flag not cleared");
  a_capture_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    cap_evt[0] |=> ccr_r[0] == $past(cnt_r) ##0 channel_match_irq[0])
    else $error("capture did not copy count");
  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    evt.ovf && ovf_clr |=> ovf_flag_r ##1 1'b1)
    else $error("overflow lost to clear");

endmodule // cc_timer

/* design/_unused_placeholder_removed.sv */
// Empty on purpose: no logic
`timescale 1ns/1ps

/* test/capture_source.sv */
// Model of the trigger sources that drive the timer's capture pins
`timescale 1ns/1ps
module capture_source (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] fire,
  input  wire logic [3:0] capture_sel,
  output logic      [3:0] capture_input_pin
);
  logic [3:0] level_r;
  logic [3:0] hold_r;

  // capture pins only
  // A pin left to compare is never pulsed, so its output use stays clean
  assign capture_input_pin = level_r & capture_sel;

  // Pulse held for several clocks so the synchroniser cannot miss it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= 4'h0;
      hold_r  <= 4'h0;
    end else if (|fire) begin
      level_r <= level_r | fire;
      hold_r  <= 4'h8;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end else begin
      level_r <= 4'h0;
    end
  end
endmodule // capture_source

/* test/testbench.sv */
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module testbench;
  localparam int LIMIT = 90000;
  localparam logic [31:0] CTRL_FREE = {27'h0, cc_timer_pkg::MODE_FREE, 2'h2};
  localparam logic [31:0] CTRL_PWM  = {27'h0, cc_timer_pkg::MODE_PWM, 2'h2};

  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [3:0]  capture_input_pin;
  logic [3:0]  timer_output_pin;
  logic [3:0]  channel_match_irq;
  logic        counter_overflow_irq;
  logic        irq;
  logic [3:0]  fire;
  logic [3:0]  capture_sel;
  logic [1:0]  rsp;
  logic [31:0] rd;
  logic [31:0] cnt;
  int          n;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cycles = 0;

  cc_timer dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .capture_input_pin(capture_input_pin),
    .timer_output_pin(timer_output_pin),
    .channel_match_irq(channel_match_irq),
    .counter_overflow_irq(counter_overflow_irq), .irq(irq));

  capture_source src (.aclk(aclk), .aresetn(aresetn), .fire(fire),
    .capture_sel(capture_sel), .capture_input_pin(capture_input_pin));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic close_out;
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hung handshake ends here; each event wait stops at its own limit
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Watches one channel until its pulse; reports whether the pin moved
  // on that same edge, which tells early from late interrupt timing
  task automatic wait_irq(input int ch, input logic early, input int lim,
                          output int waited);
    logic [3:0] prev;
    logic       hit;
    prev = timer_output_pin;
    hit = 1'b0;
    waited = 0;
    while (!hit && waited < lim) begin
      @(posedge aclk);
      hit = (channel_match_irq[ch] === 1'b1);
      if (!hit) prev = timer_output_pin;
      waited = waited + 1;
    end
    check("irq seen", {31'h0, hit}, 32'h1); // match pulse
    check("irq timing", {31'h0, timer_output_pin[ch] != prev[ch]},
          {31'h0, early}); // irq timing
  endtask

  task automatic t_reset_values;
    check("outputs", {22'h0, timer_output_pin, channel_match_irq,
          counter_overflow_irq, irq}, 32'h0);
    bus_read(cc_timer_pkg::OFF_COUNT, rd, rsp);
    check("count idle", rd, {16'h0, cc_timer_pkg::CNT_IDLE});
    bus_read(cc_timer_pkg::OFF_PRESC, rd, rsp);
    check("presc", rd, {24'h0, cc_timer_pkg::PRESC_RST});
    bus_read(cc_timer_pkg::OFF_MASK, rd, rsp);
    check("mask", rd, {27'h0, cc_timer_pkg::MASK_RST});
    bus_read(8'h30, rd, rsp);
    check("unmapped rd", {rd[29:0], rsp}, {30'h0, cc_timer_pkg::RESP_SLVERR});
    bus_write(8'h30, 32'h0000_00ff, rsp);
    check("unmapped wr", {30'h0, rsp}, {30'h0, cc_timer_pkg::RESP_SLVERR});
    bus_write(cc_timer_pkg::OFF_COUNT, 32'h0000_1234, rsp);
    bus_read(cc_timer_pkg::OFF_COUNT, rd, rsp);
    check("count ro", rd, {16'h0, cc_timer_pkg::CNT_IDLE});
  endtask

  task automatic t_compare;
    // Two clocks per count so early and late irq timing differ
    bus_write(cc_timer_pkg::OFF_PRESC, 32'h0000_0001, rsp);
    for (int i = 0; i < 4; i++)
      bus_write(cc_timer_pkg::OFF_CCR0 + 8'(4 * i), 32'(i + 1) << 8, rsp);
    bus_write(cc_timer_pkg::OFF_CTRL, CTRL_FREE, rsp);
    bus_read(cc_timer_pkg::OFF_CTRL, rd, rsp);
    check("ctrl", rd, {28'h0, cc_timer_pkg::MODE_FREE, 1'b1});
    check("start pins", {28'h0, timer_output_pin}, 32'hf);
    wait_irq(0, 1'b0, 600, n);
    check("pin0 toggled", {28'h0, timer_output_pin}, 32'he);
    bus_read(cc_timer_pkg::OFF_COUNT, cnt, rsp);
    check("no clear", {31'h0, cnt[15:0] > 16'h0100}, 32'h1);
    bus_write(cc_timer_pkg::OFF_CCR0 + 8'h4, cnt + 32'h40, rsp);
    wait_irq(1, 1'b0, 160, n);
    check("early reach", {31'h0, n < 160}, 32'h1); // anytime write
  endtask

  task automatic t_capture;
    capture_sel <= 4'h4;
    bus_write(cc_timer_pkg::OFF_OPTION, 32'h0000_0040, rsp);
    fire <= 4'h4;
    @(posedge aclk);
    fire <= 4'h0;
    wait_irq(2, 1'b0, 20, n);
    bus_read(cc_timer_pkg::OFF_CCR0 + 8'h8, rd, rsp);
    bus_read(cc_timer_pkg::OFF_COUNT, cnt, rsp);
    check("captured", {31'h0, cnt - rd < 32'h20}, 32'h1);
    check("still runs", {31'h0, cnt != rd}, 32'h1); // counting on
    bus_write(cc_timer_pkg::OFF_CCR0 + 8'h8, 32'h0000_1234, rsp);
    bus_read(cc_timer_pkg::OFF_CCR0 + 8'h8, cnt, rsp);
    check("capture kept", cnt, rd); // capture select
  endtask

  task automatic t_irq;
    bus_write(cc_timer_pkg::OFF_MASK, 32'h0000_0004, rsp);
    check("irq on", {31'h0, irq}, 32'h1); // capture irq
    bus_write(cc_timer_pkg::OFF_STATUS, 32'h0000_0004, rsp);
    @(posedge aclk);
    check("irq cleared", {31'h0, irq}, 32'h0); // status clear
    bus_write(cc_timer_pkg::OFF_MASK, 32'h0, rsp);
    fire <= 4'h4;
    @(posedge aclk);
    fire <= 4'h0;
    repeat (12) @(posedge aclk);
    bus_read(cc_timer_pkg::OFF_STATUS, rd, rsp);
    check("status sticky", {rd[2], irq}, 2'h2); // capture event
  endtask

  task automatic t_pwm;
    capture_sel <= 4'h0;
    bus_write(cc_timer_pkg::OFF_OPTION, 32'h0, rsp);
    bus_write(cc_timer_pkg::OFF_CTRL, 32'h0, rsp);
    bus_write(cc_timer_pkg::OFF_CTRL, CTRL_PWM, rsp);
    bus_read(cc_timer_pkg::OFF_COUNT, cnt, rsp);
    bus_write(cc_timer_pkg::OFF_CCR0 + 8'hc, cnt + 32'h30, rsp);
    wait_irq(3, 1'b1, 160, n);
    bus_write(cc_timer_pkg::OFF_CTRL, 32'h0, rsp);
    bus_write(cc_timer_pkg::OFF_PRESC, 32'h0, rsp);
    bus_write(cc_timer_pkg::OFF_CTRL, CTRL_FREE, rsp);
  endtask

  // Software side of interval and pulse width use
  task automatic t_software;
    logic [31:0] ccr_val;
    logic [31:0] old_cap;
    logic [31:0] width;
    int          soft_overflow_copy_a;
    int          t_gap;
    soft_overflow_copy_a = 0;
    bus_write(cc_timer_pkg::OFF_CTRL, 32'h0, rsp);
    bus_write(cc_timer_pkg::OFF_PRESC, 32'h0000_0001, rsp);
    // first load is interval minus one
    ccr_val = 32'h0000_007f;
    bus_write(cc_timer_pkg::OFF_CCR0, ccr_val, rsp);
    bus_write(cc_timer_pkg::OFF_CTRL, CTRL_FREE, rsp);
    wait_irq(0, 1'b0, 600, n); // first interval
    // reload adds interval, wraps past FFFFH
    ccr_val = ccr_val + 32'h80;
    if (ccr_val > 32'hffff) ccr_val = ccr_val - 32'h10000;
    bus_write(cc_timer_pkg::OFF_CCR0, ccr_val, rsp);
    wait_irq(0, 1'b0, 600, n);
    check("interval", {31'h0, n > 200 && n < 256}, 32'h1);
    capture_sel <= 4'h4;
    bus_write(cc_timer_pkg::OFF_OPTION, 32'h0000_0040, rsp);
    fire <= 4'h4;
    t_gap = cycles;
    @(posedge aclk);
    fire <= 4'h0;
    wait_irq(2, 1'b0, 20, n);
    // width is the difference of two readings
    bus_read(cc_timer_pkg::OFF_CCR0 + 8'h8, old_cap, rsp);
    repeat (100) @(posedge aclk);
    fire <= 4'h4;
    t_gap = cycles - t_gap;
    @(posedge aclk);
    fire <= 4'h0;
    wait_irq(2, 1'b0, 20, n);
    // overflows kept in a software copy
    bus_read(cc_timer_pkg::OFF_OPTION, rd, rsp);
    if (rd[0]) begin
      soft_overflow_copy_a = soft_overflow_copy_a + 1;
      bus_write(cc_timer_pkg::OFF_OPTION, 32'h0000_0040, rsp);
    end
    bus_read(cc_timer_pkg::OFF_CCR0 + 8'h8, rd, rsp);
    width = 32'(soft_overflow_copy_a) * 32'h10000 + rd - old_cap;
    check("pulse width", {31'h0, width + 1 >= 32'(t_gap / 2) &&
          width <= 32'(t_gap / 2 + 1)}, 32'h1);
  endtask

  task automatic t_overflow;
    n = 0;
    while (counter_overflow_irq !== 1'b1 && n < 70000) begin
      @(posedge aclk);
      n = n + 1;
    end
    check("ovf pulse", {31'h0, counter_overflow_irq}, 32'h1);
    bus_read(cc_timer_pkg::OFF_COUNT, cnt, rsp);
    check("wrapped", {31'h0, cnt < 32'h20}, 32'h1); // wrap to 0000H
    bus_read(cc_timer_pkg::OFF_OPTION, rd, rsp);
    check("ovf flag", {31'h0, rd[0]}, 32'h1); // sticky flag
    bus_read(cc_timer_pkg::OFF_STATUS, rd, rsp);
    check("ovf status", {31'h0, rd[4]}, 32'h1); // event bit
    bus_write(cc_timer_pkg::OFF_OPTION, 32'h0000_0001, rsp);
    bus_read(cc_timer_pkg::OFF_OPTION, rd, rsp);
    check("flag held", {31'h0, rd[0]}, 32'h1); // bit0 one
    bus_write(cc_timer_pkg::OFF_OPTION, 32'h0, rsp);
    bus_read(cc_timer_pkg::OFF_OPTION, rd, rsp);
    check("flag cleared", {31'h0, rd[0]}, 32'h0); // clear write
  endtask

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    fire = 4'h0;
    capture_sel = 4'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values;
    t_compare;
    t_capture;
    t_irq;
    t_pwm;
    t_overflow;
    t_software;
    close_out;
  end
endmodule // testbench
